// [rtl/ccl_pkg.sv]
package ccl_pkg;
  localparam int NUM_CH = 8;
  localparam int WORD_W = 36;
  localparam int CLEAR_AW = 15;
  localparam logic [WORD_W-1:0] ENTRY_RST = 36'h000000000;
  localparam int ADDR_FIELD_W = 15;
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFF_STATUS = 12'h000;
  localparam logic [APB_AW-1:0] OFF_CHAN = 12'h004;
  localparam logic [APB_AW-1:0] OFF_ENTRY = 12'h008;
  localparam logic [APB_AW-1:0] OFF_CTRL = 12'h00C;
  localparam int ST_ACOV = 0;
  localparam int ST_DIVCK = 1;
  localparam int ST_IOCK = 2;
  localparam int ST_PSTOP = 3;
  localparam int ST_MSTOP = 4;
  localparam int ST_READY = 5;
  localparam int ST_AUTO = 6;
  localparam int ST_TRAPCTL = 7;
  localparam int ST_CLEARING = 8;
  localparam int CHAN_SEL_LSB = 0;
  localparam int CHAN_TCK_LSB = 8;
  localparam int CTRL_AUTO = 0;

  typedef struct packed {
    logic acc_carry_out;
    logic tno_exec;
    logic tov_exec;
    logic fix_div_ge;
    logic flt_div_zero;
    logic flt_div_big;
    logic halt_exec;
    logic chan_cmd_unsel;
    logic underrun;
    logic overrun;
    logic io_check_test;
    logic instr_done;
    logic io_busy;
    logic trap_mode;
    logic cpu_running;
  } ccl_cpu_t;

  typedef struct packed {
    logic [NUM_CH-1:0] ch_active;
    logic [NUM_CH-1:0] cmd_trap_en;
    logic [NUM_CH-1:0] tck_trap_en;
    logic [NUM_CH-1:0] write_err;
    logic [NUM_CH-1:0] read_hi_err;
    logic [NUM_CH-1:0] read_lo_err;
    logic [NUM_CH-1:0] rc_exec;
    logic [NUM_CH-1:0] in_trap;
    logic rw_select;
  } ccl_chan_t;

  typedef struct packed {
    logic start;
    logic clear;
    logic load;
    logic reset;
    logic entry_reset;
    logic disp_store;
    logic disp_ind;
    logic power_on;
  } ccl_keys_t;

  typedef struct packed {
    logic interlock_rst;
    logic operator_rst;
    logic poweron_rst;
    logic cycle_hold_n;
    logic store_force;
    logic ones_inhibit;
    logic [CLEAR_AW-1:0] clear_addr;
    logic disp_store_req;
    logic disp_ind_req;
    logic [ADDR_FIELD_W-1:0] disp_addr;
  } ccl_ctl_t;
endpackage : ccl_pkg

// [rtl/ccl_console.sv]
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
// Notes on behaviour
// - Register lamps lit for one, dark zero
// - Trap lamp follows transfer trapping mode
// - Overflow sets on carry; clears on tests
// - Select lamp on until unit disconnects
// - Divide check on fixed or float fault
// - One select lamp per channel A-H
// - Trap enable lamps follow channel enables
// - Tape check latch set on errors
// - Trap control dark while trap executes
// - Halt sets program stop; manual start clears
// - I-O check on faults; test clears
// - Ready lit except in automatic status
// - Automatic lamp on running or channels
// - Interlock reset from load, clear, power
// - Reset key gives operator reset
// - Power-on reset does not zero storage
// - Manual stops after instruction and I-O
// - Keys gated by automatic or manual status
// - Thirty-six entry keys, reset to zero
// - Automatic start clears master stop
// - Clear key zeroes storage, ones inhibited
// - Display keys only in manual status
// - Master stop drives cycle hold gate
module ccl_console #(
  parameter int NUM_CH = ccl_pkg::NUM_CH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire ccl_pkg::ccl_cpu_t cpu_in,
  input wire ccl_pkg::ccl_chan_t chan_in,
  input wire ccl_pkg::ccl_keys_t keys_in,
  input wire logic [ccl_pkg::WORD_W-1:0] entry_keys_in,
  input wire logic auto_sw_in,
  input wire logic [ccl_pkg::APB_AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output ccl_pkg::ccl_ctl_t ctl_out,
  output logic trap_lamp_out,
  output logic acov_lamp_out,
  output logic rw_lamp_out,
  output logic divck_lamp_out,
  output logic [NUM_CH-1:0] chsel_lamp_out,
  output logic [NUM_CH-1:0] cmdtrap_lamp_out,
  output logic [NUM_CH-1:0] tcktrap_lamp_out,
  output logic [NUM_CH-1:0] tapeck_lamp_out,
  output logic trapctl_lamp_out,
  output logic pstop_lamp_out,
  output logic iock_lamp_out,
  output logic ready_lamp_out,
  output logic auto_lamp_out,
  output logic mstop_lamp_out,
  output logic [ccl_pkg::WORD_W-1:0] entry_out
);
  import ccl_pkg::*;

  // ************************************************************
  // Key synchronisers
  // ************************************************************
  localparam int KW = 8 + WORD_W + 1;
  logic [KW-1:0] key_s1_r, key_s2_r, key_d_r;
  logic [KW-1:0] key_raw;
  assign key_raw = {keys_in, entry_keys_in, auto_sw_in};
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_s1_r <= '0;
      key_s2_r <= '0;
      key_d_r <= '0;
    end else if (ce_in) begin
      key_s1_r <= key_raw;
      key_s2_r <= key_s1_r;
      key_d_r <= key_s2_r;
    end
  end
  ccl_keys_t ks, kp;
  logic [WORD_W-1:0] ent_s;
  logic sw_auto;
  assign ks = ccl_keys_t'(key_s2_r[KW-1 -: 8]);
  assign ent_s = key_s2_r[WORD_W:1];
  assign sw_auto = key_s2_r[0];
  // Press edges so a held key acts once
  assign kp = ccl_keys_t'(key_s2_r[KW-1 -: 8] & ~key_d_r[KW-1 -: 8]);

  // ************************************************************
  // Status, key gating and resets
  // ************************************************************
  logic auto_st_r, auto_sel_r, mstop_r, clearing_r;
  logic [CLEAR_AW-1:0] clr_cnt_r;
  logic automatic_st;
  assign automatic_st = auto_sel_r;
  logic il_rst, op_rst, po_rst, any_rst;
  // Load and clear keys act only in automatic status
  assign il_rst = ((kp.load || kp.clear) && automatic_st) || kp.power_on || op_rst;
  assign op_rst = kp.reset || po_rst;
  assign po_rst = kp.power_on || (kp.clear && automatic_st);
  assign any_rst = il_rst;
  logic start_auto, start_man, clear_go, disp_s, disp_i;
  assign start_auto = kp.start && automatic_st;
  assign start_man = kp.start && !automatic_st;
  assign clear_go = kp.clear && automatic_st;
  assign disp_s = kp.disp_store && !automatic_st;
  assign disp_i = kp.disp_ind && !automatic_st;

  // Software may stand in for the switch; hardware switch wins when on
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_sel_r <= 1'b0;
    end else if (ce_in) begin
      auto_sel_r <= sw_auto || auto_st_r;
    end
  end

  // ************************************************************
  // Master stop and cycle hold
  // ************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mstop_r <= 1'b1;
    end else if (ce_in) begin
      if (any_rst) begin
        mstop_r <= 1'b1;
      end else if (start_auto) begin
        mstop_r <= 1'b0;
      end else if (!automatic_st && !mstop_r) begin
        // Waits for the instruction and the unit to finish
        if (cpu_in.instr_done && !cpu_in.io_busy && !chan_in.rw_select) begin
          mstop_r <= 1'b1;
        end
      end else if (cpu_in.halt_exec) begin
        mstop_r <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Status latches, set wins over clear
  // ************************************************************
  logic acov_r, divck_r, iock_r, pstop_r;
  logic [NUM_CH-1:0] tapeck_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acov_r <= 1'b0;
      divck_r <= 1'b0;
      iock_r <= 1'b0;
      pstop_r <= 1'b0;
    end else if (ce_in) begin
      if (cpu_in.acc_carry_out) begin
        acov_r <= 1'b1;
      end else if (cpu_in.tno_exec || cpu_in.tov_exec || any_rst) begin
        acov_r <= 1'b0;
      end
      if (cpu_in.fix_div_ge || cpu_in.flt_div_zero || cpu_in.flt_div_big) begin
        divck_r <= 1'b1;
      end else if (any_rst) begin
        divck_r <= 1'b0;
      end
      if (cpu_in.chan_cmd_unsel || cpu_in.underrun || cpu_in.overrun) begin
        iock_r <= 1'b1;
      end else if (cpu_in.io_check_test || any_rst) begin
        iock_r <= 1'b0;
      end
      if (cpu_in.halt_exec) begin
        pstop_r <= 1'b1;
      end else if (start_man || any_rst) begin
        pstop_r <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          tapeck_r[g] <= 1'b0;
        end else if (ce_in) begin
          if (chan_in.write_err[g] || (chan_in.read_hi_err[g] && chan_in.read_lo_err[g])) begin
            tapeck_r[g] <= 1'b1;
          end else if (chan_in.rc_exec[g] || any_rst) begin
            tapeck_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Clear storage and display requests
  // ************************************************************
  logic dsr_r, dir_r;
  logic [ADDR_FIELD_W-1:0] daddr_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clearing_r <= 1'b0;
      clr_cnt_r <= '0;
    end else if (ce_in) begin
      if (clear_go) begin
        clearing_r <= 1'b1;
        clr_cnt_r <= '0;
      end else if (clearing_r) begin
        clr_cnt_r <= clr_cnt_r + CLEAR_AW'(1);
        if (&clr_cnt_r) begin
          clearing_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dsr_r <= 1'b0;
      dir_r <= 1'b0;
      daddr_r <= '0;
    end else if (ce_in) begin
      dsr_r <= disp_s;
      dir_r <= disp_i;
      if (disp_s) begin
        daddr_r <= entry_out[ADDR_FIELD_W-1:0];
      end
    end
  end

  // ************************************************************
  // Entry keys
  // ************************************************************
  logic [WORD_W-1:0] entry_r;
  logic ent_zero_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ent_zero_r <= 1'b1;
    end else if (ce_in) begin
      if (ks.entry_reset || kp.reset) begin
        ent_zero_r <= 1'b1;
      end else if (ent_s != key_d_r[WORD_W:1]) begin
        ent_zero_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      entry_r <= ENTRY_RST;
    end else if (ce_in) begin
      entry_r <= (ks.entry_reset || ent_zero_r) ? ENTRY_RST : ent_s;
    end
  end
  assign entry_out = entry_r;

  // ************************************************************
  // Lamps
  // ************************************************************
  logic any_trap;
  assign any_trap = |chan_in.in_trap;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      trap_lamp_out <= 1'b0;
      rw_lamp_out <= 1'b0;
      chsel_lamp_out <= '0;
      cmdtrap_lamp_out <= '0;
      tcktrap_lamp_out <= '0;
      trapctl_lamp_out <= 1'b1;
      auto_lamp_out <= 1'b0;
      ready_lamp_out <= 1'b1;
    end else if (ce_in) begin
      trap_lamp_out <= cpu_in.trap_mode;
      rw_lamp_out <= chan_in.rw_select;
      chsel_lamp_out <= chan_in.ch_active;
      cmdtrap_lamp_out <= chan_in.cmd_trap_en;
      tcktrap_lamp_out <= chan_in.tck_trap_en;
      trapctl_lamp_out <= !any_trap;
      auto_lamp_out <= (cpu_in.cpu_running && automatic_st) || |chan_in.ch_active;
      ready_lamp_out <= !automatic_st;
    end
  end
  assign acov_lamp_out = acov_r;
  assign divck_lamp_out = divck_r;
  assign iock_lamp_out = iock_r;
  assign pstop_lamp_out = pstop_r;
  assign tapeck_lamp_out = tapeck_r;
  assign mstop_lamp_out = mstop_r;

  always_comb begin
    ctl_out = '0;
    ctl_out.interlock_rst = il_rst;
    ctl_out.operator_rst = op_rst;
    ctl_out.poweron_rst = po_rst;
    ctl_out.cycle_hold_n = !mstop_r;
    ctl_out.store_force = clearing_r;
    ctl_out.ones_inhibit = clearing_r;
    ctl_out.clear_addr = clr_cnt_r;
    ctl_out.disp_store_req = dsr_r;
    ctl_out.disp_ind_req = dir_r;
    ctl_out.disp_addr = daddr_r;
  end

  // ************************************************************
  // APB slave, zero wait states
  // ************************************************************
  logic wr_en;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign pready_out = 1'b1;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_st_r <= 1'b0;
    end else if (ce_in) begin
      if (wr_en && paddr_in == OFF_CTRL) begin
        auto_st_r <= pwdata_in[CTRL_AUTO];
      end
    end
  end
  always_comb begin
    prdata_out = 32'h00000000;
    pslverr_out = 1'b0;
    unique case (paddr_in)
      OFF_STATUS: begin
        prdata_out[ST_ACOV] = acov_r;
        prdata_out[ST_DIVCK] = divck_r;
        prdata_out[ST_IOCK] = iock_r;
        prdata_out[ST_PSTOP] = pstop_r;
        prdata_out[ST_MSTOP] = mstop_r;
        prdata_out[ST_READY] = ready_lamp_out;
        prdata_out[ST_AUTO] = auto_lamp_out;
        prdata_out[ST_TRAPCTL] = trapctl_lamp_out;
        prdata_out[ST_CLEARING] = clearing_r;
      end
      OFF_CHAN: begin
        prdata_out[CHAN_SEL_LSB +: NUM_CH] = chsel_lamp_out;
        prdata_out[CHAN_TCK_LSB +: NUM_CH] = tapeck_r;
      end
      OFF_ENTRY: prdata_out = entry_r[31:0];
      OFF_CTRL: prdata_out[CTRL_AUTO] = auto_st_r;
      default: pslverr_out = psel_in && penable_in;
    endcase
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_ovf_set: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && cpu_in.acc_carry_out |=> acov_lamp_out) else $error("overflow not set");
  a_ovf_clr: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !cpu_in.acc_carry_out && cpu_in.tov_exec |=> !acov_lamp_out)
    else $error("overflow not cleared");
  a_iock_set: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && cpu_in.overrun |=> iock_lamp_out) else $error("io check not set");
  a_pstop_set: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && cpu_in.halt_exec |=> pstop_lamp_out) else $error("halt lost");
  a_start_run: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && start_auto && !any_rst |=> ctl_out.cycle_hold_n) else $error("start failed");
  a_ready_auto: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && automatic_st |=> !ready_lamp_out) else $error("ready lit in auto");
  a_trapctl_dark: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && |chan_in.in_trap |=> !trapctl_lamp_out) else $error("trap control lit");
  a_disp_manual: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_out.disp_store_req |-> $past(!automatic_st)) else $error("display in auto");
  a_tape_check: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && chan_in.write_err[0] |=> tapeck_lamp_out[0]) else $error("tape check lost");
endmodule : ccl_console

// [tb/ccl_far_model.sv]
`timescale 1ns/100ps
// ****************
// Far side model
// ****************
module ccl_far_model (
  input wire logic clk_in,
  output ccl_pkg::ccl_cpu_t cpu_out,
  output ccl_pkg::ccl_chan_t chan_out,
  output ccl_pkg::ccl_keys_t keys_out
);
  import ccl_pkg::*;
  initial begin
    cpu_out = '0;
    chan_out = '0;
    keys_out = '0;
  end
  task pulse_cpu(input ccl_cpu_t m);
    cpu_out <= cpu_out | m;
    @(posedge clk_in);
    cpu_out <= cpu_out & ~m;
  endtask : pulse_cpu
  task pulse_chan(input ccl_chan_t m);
    chan_out <= chan_out | m;
    @(posedge clk_in);
    chan_out <= chan_out & ~m;
  endtask : pulse_chan
  // Held past the two-stage synchroniser, then a quiet gap
  task press(input ccl_keys_t m);
    keys_out <= keys_out | m;
    repeat (4) @(posedge clk_in);
    keys_out <= keys_out & ~m;
    repeat (4) @(posedge clk_in);
  endtask : press
endmodule : ccl_far_model

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
  import ccl_pkg::*;
  logic clk_in = 0;
  logic rst_in = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic clr = 0;
  logic auto_sw = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [35:0] entry = '0;
  logic [35:0] entry_q;
  logic trap_l, acov_l, rw_l, divck_l, trapctl_l, pstop_l, iock_l, ready_l, auto_l, mstop_l;
  logic [7:0] chsel_l, cmd_l, tck_l, tape_l;
  logic [4:0] seen = '0;
  logic [14:0] daddr = '0;
  ccl_cpu_t cpu;
  ccl_chan_t chan;
  ccl_keys_t keys;
  ccl_ctl_t ctl;
  int failures = 0;
  int checks_done = 0;
  always #25 clk_in = ~clk_in;
  ccl_far_model u_far (.clk_in(clk_in), .cpu_out(cpu), .chan_out(chan), .keys_out(keys));
  ccl_console u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .cpu_in(cpu),
    .chan_in(chan), .keys_in(keys), .entry_keys_in(entry), .auto_sw_in(auto_sw),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ctl_out(ctl), .trap_lamp_out(trap_l), .acov_lamp_out(acov_l), .rw_lamp_out(rw_l),
    .divck_lamp_out(divck_l), .chsel_lamp_out(chsel_l), .cmdtrap_lamp_out(cmd_l),
    .tcktrap_lamp_out(tck_l), .tapeck_lamp_out(tape_l), .trapctl_lamp_out(trapctl_l),
    .pstop_lamp_out(pstop_l), .iock_lamp_out(iock_l), .ready_lamp_out(ready_l),
    .auto_lamp_out(auto_l), .mstop_lamp_out(mstop_l), .entry_out(entry_q));
  // ****************
  // Pulse catcher
  // ****************
  // Sticky, since reset and request pulses last one cycle only
  always @(posedge clk_in) begin
    seen <= clr ? '0 : seen | {ctl.disp_ind_req, ctl.disp_store_req, ctl.poweron_rst,
      ctl.operator_rst, ctl.interlock_rst};
    if (ctl.disp_store_req) daddr <= ctl.disp_addr;
  end
  // ****************
  // Shared tasks
  // ****************
  task complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_in);
  endtask : apb
  task clr_mon;
    clr <= 1;
    @(posedge clk_in);
    clr <= 0;
  endtask : clr_mon
  task do_reset;
    rst_in <= 1;
    tick(4);
    rst_in <= 0;
    tick(1);
  endtask : do_reset
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    chk({trapctl_l, ready_l, mstop_l, acov_l, pstop_l, iock_l, divck_l}, 7'h70, "rst lamps");
    chk(ctl.cycle_hold_n, 0, "rst hold");
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'h000000B0, "status");
    apb(1, OFF_CHAN, 32'hFFFFFFFF);
    apb(0, OFF_CHAN, 0);
    chk(rd, 0, "chan ro");
    apb(0, 12'h010, 0);
    chk(err, 1, "unmapped");
    $display("reset test done");
  endtask : t_reset
  task t_latches;
    ccl_cpu_t m[3];
    ccl_cpu_t c[2];
    m = '{'{fix_div_ge: 1, default: 0}, '{flt_div_zero: 1, default: 0},
      '{flt_div_big: 1, default: 0}};
    c = '{'{tno_exec: 1, default: 0}, '{tov_exec: 1, default: 0}};
    for (int i = 0; i < 2; i++) begin
      u_far.pulse_cpu('{acc_carry_out: 1, default: 0});
      tick(2);
      chk(acov_l, 1, "ovf set");
      u_far.pulse_cpu(c[i]);
      tick(2);
      chk(acov_l, 0, "ovf clr");
    end
    for (int i = 0; i < 3; i++) begin
      do_reset();
      u_far.pulse_cpu(m[i]);
      tick(2);
      chk(divck_l, 1, "divck");
    end
    m = '{'{chan_cmd_unsel: 1, default: 0}, '{underrun: 1, default: 0},
      '{overrun: 1, default: 0}};
    for (int i = 0; i < 3; i++) begin
      u_far.pulse_cpu(m[i]);
      tick(2);
      chk(iock_l, 1, "iock set");
      u_far.pulse_cpu('{io_check_test: 1, default: 0});
      tick(2);
      chk(iock_l, 0, "iock clr");
    end
    $display("latch test done");
  endtask : t_latches
  task t_chan;
    u_far.chan_out.ch_active <= 8'hA5;
    u_far.chan_out.cmd_trap_en <= 8'h3C;
    u_far.chan_out.tck_trap_en <= 8'hC3;
    u_far.chan_out.rw_select <= 1;
    u_far.cpu_out.trap_mode <= 1;
    tick(3);
    chk({chsel_l, cmd_l, tck_l}, 24'hA53CC3, "chan lamps");
    chk({rw_l, trap_l, auto_l, ready_l}, 4'hF, "rw trap auto");
    u_far.pulse_chan('{write_err: 8'h01, read_hi_err: 8'h06, read_lo_err: 8'h0C, default: 0});
    tick(2);
    chk(tape_l, 8'h05, "tape set");
    apb(0, OFF_CHAN, 0);
    chk(rd, 32'h000005A5, "chan reg");
    u_far.pulse_chan('{rc_exec: 8'h01, default: 0});
    tick(2);
    chk(tape_l, 8'h04, "tape clr");
    u_far.chan_out.in_trap <= 8'h10;
    tick(3);
    chk(trapctl_l, 0, "trapctl");
    u_far.chan_out <= '0;
    u_far.cpu_out.trap_mode <= 0;
    tick(3);
    chk({chsel_l, cmd_l, tck_l, rw_l, trap_l, auto_l, trapctl_l}, 28'h1, "idle");
    $display("channel test done");
  endtask : t_chan
  task t_stop;
    u_far.pulse_cpu('{halt_exec: 1, default: 0});
    tick(2);
    chk(pstop_l, 1, "halt");
    u_far.press('{start: 1, default: 0});
    chk({pstop_l, mstop_l}, 2'b01, "manual start");
    auto_sw <= 1;
    tick(5);
    chk(ready_l, 0, "ready auto");
    clr_mon();
    u_far.press('{disp_store: 1, default: 0});
    u_far.press('{start: 1, default: 0});
    chk({mstop_l, ctl.cycle_hold_n}, 2'b01, "auto start");
    chk(seen[4:3], 0, "display in auto");
    u_far.cpu_out.io_busy <= 1;
    auto_sw <= 0;
    tick(4);
    u_far.pulse_cpu('{instr_done: 1, default: 0});
    tick(2);
    chk(mstop_l, 0, "wait io");
    u_far.cpu_out.io_busy <= 0;
    tick(1);
    u_far.pulse_cpu('{instr_done: 1, default: 0});
    tick(2);
    chk({mstop_l, ctl.cycle_hold_n, ready_l}, 3'b101, "stopped");
    $display("stop test done");
  endtask : t_stop
  task t_display;
    entry <= 36'h912345ABC;
    tick(5);
    chk(entry_q, 36'h912345ABC, "entry");
    apb(0, OFF_ENTRY, 0);
    chk(rd, 32'h12345ABC, "entry reg");
    clr_mon();
    u_far.press('{disp_store: 1, default: 0});
    u_far.press('{disp_ind: 1, default: 0});
    chk(seen[4:3], 2'b11, "display reqs");
    chk(daddr, 15'h5ABC, "display addr");
    $display("display test done");
  endtask : t_display
  task t_resets;
    int n;
    u_far.pulse_cpu('{acc_carry_out: 1, default: 0});
    clr_mon();
    u_far.press('{load: 1, default: 0});
    chk({seen[0], acov_l}, 2'b01, "load manual");
    u_far.press('{reset: 1, default: 0});
    chk({seen[1], seen[0], acov_l}, 3'b110, "key reset");
    clr_mon();
    u_far.press('{clear: 1, default: 0});
    chk({seen[2], seen[0], ctl.store_force}, 0, "clear manual");
    apb(1, OFF_CTRL, 1);
    apb(0, OFF_CTRL, 0);
    chk(rd[0], 1, "ctrl rw");
    u_far.pulse_cpu('{acc_carry_out: 1, default: 0});
    clr_mon();
    u_far.press('{load: 1, default: 0});
    chk({seen[1:0], acov_l}, 3'b010, "load reset");
    clr_mon();
    u_far.press('{clear: 1, default: 0});
    chk({seen[2], ctl.store_force, ctl.ones_inhibit}, 3'b111, "clear auto");
    n = 0;
    while (ctl.store_force !== 1'b0 && n < 40000) begin
      tick(1);
      n++;
    end
    if (n >= 40000) begin
      failures++;
      complete_run();
    end
    apb(1, OFF_CTRL, 0);
    $display("reset key test done");
  endtask : t_resets
  initial begin
    tick(4);
    rst_in <= 0;
    tick(1);
    t_reset();
    t_latches();
    t_chan();
    t_stop();
    t_display();
    t_resets();
    complete_run();
  end
endmodule : tb
